// *** logic/dc_ctrl_pkg.sv ***
// Shared constants and carriers for the device-controller register block.
// Assumes a 16-bit parallel host bus with an A0 command/data select line.
package dc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_IE_WR  = 8'hC2;
   localparam logic [7:0] CMD_IE_RD  = 8'hC3;
   localparam logic [7:0] CMD_CFG_WR = 8'hF0;
   localparam logic [7:0] CMD_CFG_RD = 8'hF1;
   localparam logic [7:0] CMD_CNT_WR = 8'hF2;
   localparam logic [7:0] CMD_CNT_RD = 8'hF3;
   localparam logic [7:0] CMD_NONE   = 8'h00;

   // ----------------------------------------------------------------
   // Interrupt enable layout
   // ----------------------------------------------------------------
   localparam int IE_EP_LSB    = 10;
   localparam int IE_CTRL_IN   = 9;
   localparam int IE_CTRL_OUT  = 8;
   localparam int IE_SHORT     = 6;
   localparam int IE_PSOF      = 5;
   localparam int IE_SOF       = 4;
   localparam int IE_EOT       = 3;
   localparam int IE_SUSP      = 2;
   localparam int IE_RESM      = 1;
   localparam int IE_RST       = 0;
   localparam logic [31:0] IE_WRITABLE = 32'h00FF_FF7F;
   localparam logic [31:0] IE_RESET    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // DMA configuration layout
   // ----------------------------------------------------------------
   localparam int CFG_COUNT_ZERO_END_ENABLE    = 15;
   localparam int CFG_SHORT_PACKET_END_MODE    = 14;
   localparam int CFG_EPSEL_LSB = 4;
   localparam int CFG_RUN       = 3;
   localparam int CFG_BURST_LSB = 0;
   localparam logic [15:0] CNT_RESET = 16'h0000;

   typedef struct packed {
      logic       count_zero_end_enable;
      logic       short_packet_end_mode;
      logic [3:0] dma_endpoint_select;
      logic [1:0] burst_length_select;
   } dma_cfg_s;

   localparam dma_cfg_s CFG_RESET = '{1'b0, 1'b0, 4'h0, 2'h0};

   typedef struct packed {
      logic [13:0] endpoint;
      logic        ctrlIn;
      logic        ctrlOut;
      logic        shortPacket;
      logic        pseudoSof;
      logic        sof;
      logic        suspend;
      logic        resume;
      logic        busReset;
   } usb_events_s;

   function automatic logic [4:0] burst_bytes(input logic [1:0] sel);
      case (sel)
         2'h0:    burst_bytes = 5'h01;
         2'h1:    burst_bytes = 5'h04;
         2'h2:    burst_bytes = 5'h08;
         default: burst_bytes = 5'h10;
      endcase
   endfunction

endpackage

// *** logic/dma_engine.sv ***
// Byte counter, burst pacing and end-of-transfer logic for the DMA side.
// Assumes one byteAck pulse per byte moved by the external DMA controller.
`timescale 1ns/1ps
`default_nettype none
module dma_engine #(
   parameter int CNT_W = 16
) (
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   input  wire logic                   start,
   input  wire logic                   stop,
   input  wire logic                   byteAck,
   input  wire logic                   shortOut,
   input  var  dc_ctrl_pkg::dma_cfg_s  cfg,
   input  wire logic [CNT_W-1:0]       loadCount,
   output logic                        running_r,
   output logic [CNT_W-1:0]            remaining_r,
   output logic                        eot_r,
   output logic                        dmaReq_r
);
   logic [4:0]       burstCnt_r;
   logic [4:0]       burstLen;
   logic             lastByte;
   logic             countEnd;
   logic             shortEnd;
   logic             burstDone;
   logic             running_nxt;
   logic [CNT_W-1:0] remaining_nxt;
   logic [4:0]       burstCnt_nxt;

   assign burstLen  = dc_ctrl_pkg::burst_bytes(cfg.burst_length_select);
   assign lastByte  = running_r && byteAck && remaining_r == CNT_W'(1);
   assign countEnd  = lastByte && cfg.count_zero_end_enable;
   assign shortEnd  = running_r && shortOut
                      && cfg.short_packet_end_mode;
   // Request drops for one cycle between bursts so the DMA controller
   // rearbitrates, which is what it expects of a burst boundary.
   assign burstDone = byteAck && burstCnt_r == burstLen - 5'h01;
   assign running_nxt = stop ? 1'b0 :
                        (countEnd || shortEnd) ? 1'b0 :
                        start ? 1'b1 : running_r;
   assign remaining_nxt = start ? loadCount :
                          (running_r && byteAck && remaining_r != '0)
                          ? remaining_r - CNT_W'(1) : remaining_r;
   assign burstCnt_nxt = (start || burstDone) ? 5'h00 :
                         (running_r && byteAck) ? burstCnt_r + 5'h01
                         : burstCnt_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         running_r   <= 1'b0;
         remaining_r <= '0;
         burstCnt_r  <= 5'h00;
         eot_r       <= 1'b0;
         dmaReq_r    <= 1'b0;
      end else begin
         running_r   <= running_nxt;
         remaining_r <= remaining_nxt;
         burstCnt_r  <= burstCnt_nxt;
         eot_r       <= countEnd || shortEnd;
         dmaReq_r    <= running_nxt && remaining_nxt != '0 && !burstDone;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_count_zero_end: assert property (countEnd && !stop |=> eot_r
      && !running_r && remaining_r == '0)
      else $error("count end did not stop the transfer");
   a_short_end: assert property (running_r && shortOut
      && cfg.short_packet_end_mode |=> eot_r && !running_r)
      else $error("short packet did not end the transfer");
   a_stop_now: assert property (stop |=> !running_r && !dmaReq_r)
      else $error("stop did not terminate the transfer");
   a_reload_count: assert property (start |=>
      remaining_r == $past(loadCount))
      else $error("counter not reloaded on enable");
   a_burst_gap: assert property (burstDone |=> !dmaReq_r)
      else $error("request not released at burst end");
   c_burst: cover property (burstDone && cfg.burst_length_select == 2'h3);
endmodule
`default_nettype wire

// *** logic/dc_irq_enable_dma_config.sv ***
// Interrupt source enable and DMA configuration registers of the device
// controller, reached by command codes over the 16-bit parallel host bus.
// Assumes the bus strobes are single-cycle pulses synchronous to sys_clk.
//
// Notes on behaviour
// - interrupt enables: write C2, read C3, four bytes.
// - bits 23..10 enable endpoints 14..1.
// - bit 9 control IN, bit 8 control OUT.
// - bit 6 enables short packet interrupt.
// - bit 5 enables millisecond pseudo frame interrupt.
// - bit 4 frame start, bit 3 transfer end.
// - bits 2,1,0: suspend, resume, bus reset.
// - bus reset keeps interrupt enables unchanged.
// - DMA config: write F0, read F1, two bytes.
// - bus reset clears only the DMA run bit.
// - count zero mode ends transfer at zero.
// - short packet mode ends OUT transfer.
// - bits 7..4 select DMA endpoint buffer.
// - run one starts DMA, zero stops at once.
// - run bit reads back actual DMA state.
// - burst select: 1, 4, 8, 16 bytes.
// - re-enabling reloads counter from byte count.
// - byte count writes length, reads remaining.
`timescale 1ns/1ps
`default_nettype none
module dc_irq_enable_dma_config #(
   parameter int          CNT_W  = 16,
   parameter logic [63:0] EP_MAP = 64'hFEDC_BA98_7654_3210
) (
   input  wire logic                     sys_clk,
   input  wire logic                     nrst,
   input  wire logic                     busA0,
   input  wire logic                     busWr,
   input  wire logic                     busRd,
   input  wire logic [15:0]              busDin,
   output logic [15:0]                   busDout_r,
   input  var  dc_ctrl_pkg::usb_events_s events,
   input  wire logic [31:0]              pendingClear,
   input  wire logic                     shortOutPacket,
   input  wire logic                     dmaAck,
   output logic                          irqOut_r,
   output logic                          dmaReq_r,
   output logic                          dmaEot_r,
   output logic                          dmaRun_r,
   output logic [3:0]                    dmaEndpoint_r,
   output logic [4:0]                    dmaBurstBytes_r
);
   // ----------------------------------------------------------------
   // Command and data phase decode
   // ----------------------------------------------------------------
   logic [7:0]                cmd_r;
   logic                      wordIdx_r;
   logic [31:0]               ieEnable_r;
   logic [31:0]               pending_r;
   dc_ctrl_pkg::dma_cfg_s     cfg_r;
   logic [CNT_W-1:0]          byteCount_r;
   logic [CNT_W-1:0]          remaining;
   logic                      running;
   logic                      engEot;
   logic                      engReq;

   logic                      cmdWr;
   logic                      dataWr;
   logic                      dataRd;
   logic                      ieWrLo;
   logic                      ieWrHi;
   logic                      cfgWr;
   logic                      cntWr;
   logic                      dmaStart;
   logic                      dmaStop;
   logic [31:0]               ieEnable_nxt;
   logic [31:0]               eventVec;
   logic [31:0]               pending_nxt;
   logic [15:0]               readWord;
   logic [15:0]               cfgWord;
   logic [3:0]                mappedEp;
   logic                      irq_nxt;

   assign cmdWr  = busWr && busA0;
   assign dataWr = busWr && !busA0;
   assign dataRd = busRd && !busA0;
   // Only the first data word is accepted after F0 or F2; after C2, every data
   // phase past the first rewrites the high word rather than wrapping around.
   assign ieWrLo = dataWr && cmd_r == dc_ctrl_pkg::CMD_IE_WR
                   && !wordIdx_r;
   assign ieWrHi = dataWr && cmd_r == dc_ctrl_pkg::CMD_IE_WR
                   && wordIdx_r;
   assign cfgWr  = dataWr && cmd_r == dc_ctrl_pkg::CMD_CFG_WR
                   && !wordIdx_r;
   assign cntWr  = dataWr && cmd_r == dc_ctrl_pkg::CMD_CNT_WR
                   && !wordIdx_r;

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------
   // Reserved bits are forced to zero so a careless write cannot make
   // them read back as one.
   assign ieEnable_nxt =
      ieWrLo ? {ieEnable_r[31:16], busDin} & dc_ctrl_pkg::IE_WRITABLE :
      ieWrHi ? {busDin, ieEnable_r[15:0]} & dc_ctrl_pkg::IE_WRITABLE :
      ieEnable_r;

   // ----------------------------------------------------------------
   // Event latching and interrupt output
   // ----------------------------------------------------------------
   function automatic logic [31:0] event_vector(
      input dc_ctrl_pkg::usb_events_s ev,
      input logic                     eot);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[dc_ctrl_pkg::IE_EP_LSB +: 14]  = ev.endpoint;
      v[dc_ctrl_pkg::IE_CTRL_IN]       = ev.ctrlIn;
      v[dc_ctrl_pkg::IE_CTRL_OUT]      = ev.ctrlOut;
      v[dc_ctrl_pkg::IE_SHORT]         = ev.shortPacket;
      v[dc_ctrl_pkg::IE_PSOF]          = ev.pseudoSof;
      v[dc_ctrl_pkg::IE_SOF]           = ev.sof;
      v[dc_ctrl_pkg::IE_EOT]           = eot;
      v[dc_ctrl_pkg::IE_SUSP]          = ev.suspend;
      v[dc_ctrl_pkg::IE_RESM]          = ev.resume;
      v[dc_ctrl_pkg::IE_RST]           = ev.busReset;
      return v;
   endfunction

   assign eventVec = event_vector(events, engEot);
   // A new event wins over a clear arriving in the same cycle.
   assign pending_nxt = (pending_r & ~pendingClear) | eventVec;
   assign irq_nxt     = |(pending_nxt & ieEnable_nxt);

   // ----------------------------------------------------------------
   // DMA configuration and byte count
   // ----------------------------------------------------------------
   // Run is started only on a rising enable so the counter reload
   // happens once per transfer, not on every rewrite of the register.
   assign dmaStart = cfgWr && busDin[dc_ctrl_pkg::CFG_RUN]
                     && !running && !events.busReset;
   assign dmaStop  = (cfgWr && !busDin[dc_ctrl_pkg::CFG_RUN])
                     || events.busReset;
   assign cfgWord  = {cfg_r.count_zero_end_enable,
                      cfg_r.short_packet_end_mode, 6'h00,
                      cfg_r.dma_endpoint_select, running, 1'b0,
                      cfg_r.burst_length_select};
   assign mappedEp = EP_MAP[{cfg_r.dma_endpoint_select, 2'b00} +: 4];

   assign readWord =
      cmd_r == dc_ctrl_pkg::CMD_IE_RD
         ? (wordIdx_r ? ieEnable_r[31:16] : ieEnable_r[15:0]) :
      cmd_r == dc_ctrl_pkg::CMD_CFG_RD ? cfgWord :
      cmd_r == dc_ctrl_pkg::CMD_CNT_RD ? 16'(remaining) :
      16'h0000;

   dma_engine #(
      .CNT_W (CNT_W)
   ) u_engine (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .start       (dmaStart),
      .stop        (dmaStop),
      .byteAck     (dmaAck),
      .shortOut    (shortOutPacket),
      .cfg         (cfg_r),
      .loadCount   (byteCount_r),
      .running_r   (running),
      .remaining_r (remaining),
      .eot_r       (engEot),
      .dmaReq_r    (engReq)
   );

   assign dmaReq_r = engReq;
   assign dmaEot_r = engEot;
   assign dmaRun_r = running;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_r     <= dc_ctrl_pkg::CMD_NONE;
         wordIdx_r <= 1'b0;
      end else if (cmdWr) begin
         cmd_r     <= busDin[7:0];
         wordIdx_r <= 1'b0;
      end else if (dataWr || dataRd) begin
         wordIdx_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ieEnable_r <= dc_ctrl_pkg::IE_RESET;
         pending_r  <= 32'h0000_0000;
         irqOut_r   <= 1'b0;
      end else begin
         ieEnable_r <= ieEnable_nxt;
         pending_r  <= pending_nxt;
         irqOut_r   <= irq_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= dc_ctrl_pkg::CFG_RESET;
      end else if (cfgWr) begin
         cfg_r.count_zero_end_enable <= busDin[dc_ctrl_pkg::CFG_COUNT_ZERO_END_ENABLE];
         cfg_r.short_packet_end_mode <= busDin[dc_ctrl_pkg::CFG_SHORT_PACKET_END_MODE];
         cfg_r.dma_endpoint_select   <=
            busDin[dc_ctrl_pkg::CFG_EPSEL_LSB +: 4];
         cfg_r.burst_length_select   <=
            busDin[dc_ctrl_pkg::CFG_BURST_LSB +: 2];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         byteCount_r <= CNT_W'(dc_ctrl_pkg::CNT_RESET);
      end else if (cntWr) begin
         byteCount_r <= CNT_W'(busDin);
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         busDout_r       <= 16'h0000;
         dmaEndpoint_r   <= 4'h0;
         dmaBurstBytes_r <= 5'h01;
      end else begin
         if (dataRd) begin
            busDout_r <= readWord;
         end
         dmaEndpoint_r   <= mappedEp;
         dmaBurstBytes_r <=
            dc_ctrl_pkg::burst_bytes(cfg_r.burst_length_select);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_ie_write_hi: assert property (ieWrHi |=>
      ieEnable_r[31:16] == {8'h00, $past(busDin[7:0])})
      else $error("interrupt enable high word not stored");
   a_ie_read_lo: assert property (dataRd
      && cmd_r == dc_ctrl_pkg::CMD_IE_RD && !wordIdx_r
      |=> busDout_r == $past(ieEnable_r[15:0]))
      else $error("interrupt enable low word misread");
   a_ie_keep_reset: assert property (events.busReset
      && !ieWrLo && !ieWrHi |=> $stable(ieEnable_r))
      else $error("bus reset altered interrupt enables");
   a_ep_irq: assert property (events.endpoint[0]
      && ieEnable_r[dc_ctrl_pkg::IE_EP_LSB] && !ieWrLo |=> irqOut_r)
      else $error("endpoint one interrupt missing");
   a_ctrl_irq: assert property (events.ctrlIn
      && ieEnable_r[dc_ctrl_pkg::IE_CTRL_IN] && !ieWrLo |=> irqOut_r)
      else $error("control IN interrupt missing");
   a_psof_irq: assert property (events.pseudoSof
      && ieEnable_r[dc_ctrl_pkg::IE_PSOF] && !ieWrLo |=> irqOut_r)
      else $error("pseudo frame interrupt missing");
   a_irq_masked: assert property (irqOut_r
      |-> (pending_r & ieEnable_r) != '0)
      else $error("interrupt without enabled pending event");
   a_cfg_write: assert property (cfgWr |=>
      cfg_r.dma_endpoint_select == $past(busDin[7:4])
      && cfg_r.burst_length_select == $past(busDin[1:0]))
      else $error("configuration word not stored");
   a_reset_stops: assert property (events.busReset |=>
      !dmaRun_r && $stable(cfg_r))
      else $error("bus reset did not clear only the run bit");
   a_run_readback: assert property (dataRd
      && cmd_r == dc_ctrl_pkg::CMD_CFG_RD
      |=> busDout_r[dc_ctrl_pkg::CFG_RUN] == $past(running))
      else $error("run bit readback wrong");
   a_start_run: assert property (dmaStart |=> dmaRun_r
      && $past(byteCount_r) == CNT_W'(16'(remaining)))
      else $error("enable did not start with reloaded count");
   a_ep_map: assert property (cfgWr ##1 !cfgWr |=>
      dmaEndpoint_r == EP_MAP[{cfg_r.dma_endpoint_select, 2'b00} +: 4])
      else $error("endpoint mapping wrong");

   c_ie_full_write: cover property (ieWrLo ##[1:4] ieWrHi);
   c_dma_count_end: cover property (dmaStart ##[1:100] dmaEot_r);
   c_reset_in_run: cover property (dmaRun_r && events.busReset);
   c_irq_raised: cover property (!irqOut_r ##1 irqOut_r);
endmodule
`default_nettype wire

// *** test/dma_ctrl_model.sv ***
// External DMA controller model: answers a request level with byte acks.
// Assumes the device holds its request high while it still wants bytes.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_model (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic dmaReq,
   input  wire logic slow,
   output logic      dmaAck
);
   logic tgl_r;
   // At most one ack every other cycle, so no ack lands on the edge at
   // which the device is already dropping its request after a burst.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dmaAck <= 1'h0;
         tgl_r  <= 1'h0;
      end else begin
         tgl_r  <= ~tgl_r;
         dmaAck <= dmaReq & ~dmaAck & (~slow | tgl_r);
      end
   end
endmodule
`default_nettype wire

// *** test/tb_dc_irq_enable_dma_config.sv ***
// Self-checking bench for the interrupt enable and DMA configuration block.
// Assumes the DMA controller model on the far side and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_dc_irq_enable_dma_config;
   logic                     sys_clk = 1'h0;
   logic                     nrst = 1'h0;
   logic                     busA0 = 1'h0;
   logic                     busWr = 1'h0;
   logic                     busRd = 1'h0;
   logic [15:0]              busDin = 16'h0000;
   logic [15:0]              busDout_r, cnt, cfg;
   dc_ctrl_pkg::usb_events_s events = '0;
   logic [31:0]              pendingClear = 32'h0000_0000;
   logic                     shortOutPacket = 1'h0;
   logic                     slow = 1'h0;
   logic                     dmaAck, irqOut_r, dmaReq_r, dmaEot_r, dmaRun_r;
   logic [3:0]               dmaEndpoint_r;
   logic [4:0]               dmaBurstBytes_r;
   logic [31:0]              rnd = 32'h0000_C9EA, got, ie;
   int                       nErrors = 0, compares = 0, nAck = 0;

   // The reversed buffer map shows that the select field goes through it.
   dc_irq_enable_dma_config #(.CNT_W(16), .EP_MAP(64'h0123_4567_89AB_CDEF))
      i_dc_irq_enable_dma_config (.sys_clk(sys_clk), .nrst(nrst),
      .busA0(busA0), .busWr(busWr), .busRd(busRd), .busDin(busDin),
      .busDout_r(busDout_r), .events(events), .pendingClear(pendingClear),
      .shortOutPacket(shortOutPacket), .dmaAck(dmaAck), .irqOut_r(irqOut_r),
      .dmaReq_r(dmaReq_r), .dmaEot_r(dmaEot_r), .dmaRun_r(dmaRun_r),
      .dmaEndpoint_r(dmaEndpoint_r), .dmaBurstBytes_r(dmaBurstBytes_r));
   dma_ctrl_model i_dma_ctrl_model (.sys_clk(sys_clk), .nrst(nrst),
      .dmaReq(dmaReq_r), .slow(slow), .dmaAck(dmaAck));

   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (dmaAck === 1'h1 && dmaRun_r === 1'h1) nAck++;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic dc_ctrl_pkg::usb_events_s ev_of(input logic [31:0] v);
      return '{v[23:10], v[9], v[8], v[6], v[5], v[4], v[2], v[1], v[0]};
   endfunction
   function automatic logic [4:0] bytes_of(input logic [1:0] s);
      return (s == 2'h0) ? 5'h01 : 5'h02 << s;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         nErrors++;
      end
   endtask
   task automatic print_verdict();
      $display("counts: compares=%0d mismatches=%0d", compares, nErrors);
      if (nErrors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic bus_wr(input logic a0, input logic [15:0] d);
      @(posedge sys_clk);
      busA0  <= a0;
      busWr  <= 1'h1;
      busDin <= d;
      @(posedge sys_clk);
      busWr <= 1'h0;
   endtask
   task automatic bus_rd(output logic [15:0] d);
      @(posedge sys_clk);
      busA0 <= 1'h0;
      busRd <= 1'h1;
      @(posedge sys_clk);
      busRd <= 1'h0;
      @(posedge sys_clk);
      #1 d = busDout_r;
   endtask
   task automatic wr_reg(input logic [7:0] c, input logic [31:0] v);
      bus_wr(1'h1, {8'h00, c});
      bus_wr(1'h0, v[15:0]);
      if (c == dc_ctrl_pkg::CMD_IE_WR) bus_wr(1'h0, v[31:16]);
   endtask
   task automatic rd_reg(input logic [7:0] c, output logic [31:0] v);
      logic [15:0] lo, hi;
      bus_wr(1'h1, {8'h00, c});
      bus_rd(lo);
      hi = 16'h0000;
      if (c == dc_ctrl_pkg::CMD_IE_RD) bus_rd(hi);
      v = {hi, lo};
   endtask
   task automatic pulse_ev(input logic [31:0] v);
      @(posedge sys_clk);
      events <= ev_of(v);
      @(posedge sys_clk);
      events <= '0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic clr_all();
      @(posedge sys_clk);
      pendingClear <= 32'hFFFF_FFFF;
      @(posedge sys_clk);
      pendingClear <= 32'h0000_0000;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic start_dma(input logic [15:0] c, input logic [15:0] f);
      wr_reg(dc_ctrl_pkg::CMD_CNT_WR, {16'h0000, c});
      nAck = 0;
      wr_reg(dc_ctrl_pkg::CMD_CFG_WR, {16'h0000, f});
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_eot();
      int k;
      k = 0;
      while (dmaEot_r !== 1'h1 && k < 3000) begin
         @(posedge sys_clk);
         #1 k++;
      end
      chk({31'h0, k < 3000}, 32'h1);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      #1000000 nErrors++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'h1;
      rd_reg(dc_ctrl_pkg::CMD_IE_RD, got);
      chk(got, 32'h0000_0000);
      rd_reg(dc_ctrl_pkg::CMD_CFG_RD, got);
      chk(got, 32'h0000_0000);
      chk(dmaBurstBytes_r, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr_reg(dc_ctrl_pkg::CMD_IE_WR, rnd & 32'h00FF_FFFF);
         rd_reg(dc_ctrl_pkg::CMD_IE_RD, got);
         chk(got, rnd & 32'h00FF_FF7F);
      end
      $display("test register access done");
      for (int i = 0; i < 24; i++) begin
         if (i == 3 || i == 7) continue;
         ie = 32'h1 << i;
         wr_reg(dc_ctrl_pkg::CMD_IE_WR, ie);
         pulse_ev(ie);
         chk(irqOut_r, 32'h1);
         clr_all();
         chk(irqOut_r, 32'h0);
         wr_reg(dc_ctrl_pkg::CMD_IE_WR, ~ie & 32'h00FF_FF7F);
         pulse_ev(ie);
         chk(irqOut_r, 32'h0);
         clr_all();
      end
      pulse_ev(32'h1);
      clr_all();
      rd_reg(dc_ctrl_pkg::CMD_IE_RD, got);
      chk(got, 32'h007F_FF7F);
      $display("test interrupt sources done");
      wr_reg(dc_ctrl_pkg::CMD_IE_WR, 32'h0000_0008);
      for (int b = 0; b < 4; b++) begin
         rnd = lfsr(rnd);
         slow <= rnd[8];
         cnt = {11'h000, rnd[4:0]} + 16'h0001;
         cfg = {8'h80, rnd[7:4], 2'h2, 2'(b)};
         start_dma(cnt, cfg);
         chk(dmaEndpoint_r, 32'hF - rnd[7:4]);
         chk(dmaBurstBytes_r, bytes_of(2'(b)));
         wait_eot();
         chk(nAck, cnt);
         chk(dmaRun_r, 32'h0);
         repeat (2) @(posedge sys_clk);
         #1 chk(irqOut_r, 32'h1);
         clr_all();
         rd_reg(dc_ctrl_pkg::CMD_CFG_RD, got);
         chk(got, cfg & 16'hC0F3);
      end
      $display("test count end done");
      slow <= 1'h1;
      start_dma(16'h0028, 16'h0008);
      rd_reg(dc_ctrl_pkg::CMD_CFG_RD, got);
      chk(got, 32'h0000_0008);
      repeat (12) @(posedge sys_clk);
      wr_reg(dc_ctrl_pkg::CMD_CFG_WR, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      #1 chk({dmaRun_r, dmaReq_r}, 32'h0);
      rd_reg(dc_ctrl_pkg::CMD_CNT_RD, got);
      chk(got, 32'h28 - nAck);
      nAck = 0;
      wr_reg(dc_ctrl_pkg::CMD_CFG_WR, 32'h0000_8008);
      wait_eot();
      chk(nAck, 32'h28);
      $display("test stop and reload done");
      // Short mode is used only with an OUT buffer as target.
      start_dma(16'h0100, 16'h40A9);
      repeat (9) @(posedge sys_clk);
      shortOutPacket <= 1'h1;
      // The end pulse follows the sampling edge, so the wait starts here.
      wait_eot();
      @(posedge sys_clk);
      shortOutPacket <= 1'h0;
      chk(dmaRun_r, 32'h0);
      start_dma(16'h0100, 16'h80A9);
      pulse_ev(32'h1);
      chk(dmaRun_r, 32'h0);
      rd_reg(dc_ctrl_pkg::CMD_CFG_RD, got);
      chk(got, 32'h80A1);
      $display("test short packet and bus reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
